// File: hdl/pdimf_consts.svh
`ifndef PDIMF_CONSTS_SVH
`define PDIMF_CONSTS_SVH

`define PDIMF_ADDR_W        8
`define PDIMF_OFF_PWR_ST    8'h0C
`define PDIMF_OFF_IDLE_REQ  8'h10
`define PDIMF_OFF_IDLE_ST   8'h14
`define PDIMF_OFF_MODE_CFG  8'h18
`define PDIMF_OFF_FLOW_ST   8'h1C
`define PDIMF_OFF_OSC_THR   8'h20

`define PDIMF_NUM_DOM       10
`define PDIMF_IDLE_ACK_LSB  16
`define PDIMF_IDLE_DONE_LSB 0
`define PDIMF_PWR_DOM_LSB   5
`define PDIMF_PWR_CORE_LSB  0
`define PDIMF_PWR_RSVD_BIT  4

`define PDIMF_CFG_W         23
`define PDIMF_CFG_RST       23'h000000
`define PDIMF_STEP_LSB      19
`define PDIMF_NUM_STEP      12
`define PDIMF_STEP_FIRST    4'hB
`define PDIMF_STEP_OSC      4'h1
`define PDIMF_OSC_THR_W     20
`define PDIMF_OSC_THR_RST   20'h05DC0
`define PDIMF_PAD_REL_RST   2'h3
`define PDIMF_SYNC_W        30

`endif

// File: hdl/pdimf_pkg.sv
`include "pdimf_consts.svh"

package pdimf_pkg;

	typedef enum logic [1:0]
	{
		PDIMF_ST_IDLE  = 2'h0,
		PDIMF_ST_SLEEP = 2'h1,
		PDIMF_ST_WAKE  = 2'h3,
		PDIMF_ST_OSC   = 2'h2
	} pdimf_flow_st_t;

	typedef struct packed
	{
		logic dram1_pad_hold_release_request;
		logic dram0_pad_hold_release_request;
		logic dram1_controller_auto_gate;
		logic dram0_controller_auto_gate;
		logic dram1_pad_hold_enable;
		logic dram0_pad_hold_enable;
		logic dram1_self_refresh_entry_enable;
		logic dram0_self_refresh_entry_enable;
		logic wake_reset_enable;
		logic input_clamp_enable;
		logic main_oscillator_off;
		logic manager_clock_slow_select;
		logic always_on_clock_slow_select;
		logic power_off_combine;
		logic whole_chip_off_enable;
		logic synth_off_enable;
		logic snoop_unit_off_enable;
		logic primary_core_off_enable;
		logic bus_domain_off_enable;
		logic level2_flush_enable;
		logic global_irq_disable;
		logic core_clock_gate_disable;
		logic flow_enable;
	} pdimf_mode_cfg_t;

	typedef struct packed
	{
		pdimf_flow_st_t                     st;
		logic [3:0]                         step;
		logic [`PDIMF_NUM_DOM-1:0]          idle_req;
		pdimf_mode_cfg_t                    cfg;
		logic [`PDIMF_NUM_STEP-1:0]         flow_bits;
		logic [`PDIMF_OSC_THR_W-1:0]        osc_thr;
		logic [31:0]                        prdata;
		logic [2:0]                         pwroff;
		logic [1:0]                         pad_release;
		logic                               core_gate;
	} pdimf_top_state_t;

endpackage : pdimf_pkg

// File: hdl/pdimf_sync.sv
`include "pdimf_consts.svh"

module pdimf_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,    // System clock.
	input  wire logic         presetn, // Asynchronous reset, active low.
	input  wire logic [W-1:0] din,     // Asynchronous inputs.
	output logic      [W-1:0] dout     // Synchronised inputs.
);

	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} pdimf_sync_st_t;

	pdimf_sync_st_t r_q;
	pdimf_sync_st_t r_d;

	// Only the second stage is read outside, so metastability stays in stage one.
	always_comb
	begin
		r_d    = r_q;
		r_d.s1 = din;
		r_d.s2 = r_q.s1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign dout = r_q.s2;

endmodule : pdimf_sync

// File: hdl/pdimf_stab_cnt.sv
`include "pdimf_consts.svh"

module pdimf_stab_cnt (
	input  wire logic                        pclk,    // System clock.
	input  wire logic                        presetn, // Asynchronous reset, active low.
	input  wire logic                        run,     // Count while high, clear when low.
	input  wire logic [`PDIMF_OSC_THR_W-1:0] thresh,  // Stabilisation threshold.
	output logic                             done     // Threshold reached while running.
);

	typedef struct packed
	{
		logic [`PDIMF_OSC_THR_W-1:0] cnt;
	} pdimf_cnt_st_t;

	pdimf_cnt_st_t r_q;
	pdimf_cnt_st_t r_d;

	// The count saturates so a threshold of all ones still completes.
	always_comb
	begin
		r_d = r_q;
		if (!run)
			r_d.cnt = '0;
		else if (r_q.cnt != {`PDIMF_OSC_THR_W{1'b1}})
			r_d.cnt = r_q.cnt + 20'h00001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_q <= '0;
		else
			r_q <= r_d;
	end

	assign done = run && (r_q.cnt >= thresh);

endmodule : pdimf_stab_cnt

// File: hdl/pdimf_top.sv
// Decided for this implementation: the APB slave port.
`include "pdimf_consts.svh"

module pdimf_top (
	input  wire logic                     pclk,            // System clock, 100 MHz.
	input  wire logic                     presetn,         // Asynchronous reset, active low.
	input  wire logic                     psel,            // APB select.
	input  wire logic                     penable,         // APB enable.
	input  wire logic                     pwrite,          // APB write direction.
	input  wire logic [`PDIMF_ADDR_W-1:0] paddr,           // APB byte address.
	input  wire logic [31:0]              pwdata,          // APB write data.
	output logic      [31:0]              prdata,          // APB read data.
	output logic                          pready,          // APB ready.
	output logic                          pslverr,         // APB error on unmapped address.
	input  wire logic [9:0]               idle_ack_in,     // Domain flush acknowledges.
	input  wire logic [9:0]               idle_done_in,    // Domain flush finished flags.
	input  wire logic [3:0]               domain_off_in,   // Video, video-out, peri, bus off.
	input  wire logic [3:0]               core_off_in,     // Cores 3..1 and primary core off.
	input  wire logic                     cpu_standby_in,  // Processor ready for low power.
	input  wire logic                     wake_event_in,   // Wake-up event.
	output logic      [9:0]               idle_req,        // Domain flush requests.
	output pdimf_pkg::pdimf_mode_cfg_t    mode_cfg,        // Mode flow configuration.
	output logic      [2:0]               power_off_req,   // Chip, synth, bus power-off.
	output logic      [1:0]               pad_release_req, // DRAM1, DRAM0 hold release.
	output logic                          core_clock_gate, // Core clock source gate.
	output logic                          flow_asleep,     // Flow is in low-power state.
	output logic      [11:0]              flow_steps       // Wake-up steps reached.
);

	pdimf_pkg::pdimf_top_state_t r_q;
	pdimf_pkg::pdimf_top_state_t r_d;

	logic [`PDIMF_SYNC_W-1:0] sync_s;
	logic [9:0]               ack_s;
	logic [9:0]               done_s;
	logic [3:0]               dom_s;
	logic [3:0]               core_s;
	logic                     standby_s;
	logic                     wake_s;
	logic                     osc_done;
	logic                     acc_wr;
	logic                     setup_rd;

	function automatic logic addr_mapped(input logic [`PDIMF_ADDR_W-1:0] a);
		addr_mapped = (a == `PDIMF_OFF_PWR_ST) || (a == `PDIMF_OFF_IDLE_REQ) ||
			(a == `PDIMF_OFF_IDLE_ST) || (a == `PDIMF_OFF_MODE_CFG) ||
			(a == `PDIMF_OFF_FLOW_ST) || (a == `PDIMF_OFF_OSC_THR);
	endfunction : addr_mapped

	function automatic logic step_enabled(input logic [3:0] idx,
		input pdimf_pkg::pdimf_mode_cfg_t c);
		case (idx)
			4'hB: step_enabled = 1'b1;
			4'hA: step_enabled = 1'b1;
			4'h9: step_enabled = c.primary_core_off_enable;
			4'h8: step_enabled = c.snoop_unit_off_enable;
			4'h7: step_enabled = c.dram1_self_refresh_entry_enable |
				c.dram0_self_refresh_entry_enable;
			4'h6: step_enabled = c.dram1_pad_hold_enable | c.dram0_pad_hold_enable;
			4'h5: step_enabled = c.bus_domain_off_enable;
			4'h4: step_enabled = c.synth_off_enable;
			4'h3: step_enabled = c.wake_reset_enable;
			4'h2: step_enabled = c.manager_clock_slow_select |
				c.always_on_clock_slow_select;
			4'h1: step_enabled = c.main_oscillator_off;
			4'h0: step_enabled = c.input_clamp_enable;
			default: step_enabled = 1'b0;
		endcase
	endfunction : step_enabled

	// Domain handshakes and status come from other power islands, so all are synchronised.
	pdimf_sync #(
		.W (`PDIMF_SYNC_W)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     ({cpu_standby_in, wake_event_in, domain_off_in, core_off_in,
			idle_ack_in, idle_done_in}),
		.dout    (sync_s)
	);

	assign {standby_s, wake_s, dom_s, core_s, ack_s, done_s} = sync_s;

	pdimf_stab_cnt u_osc_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (r_q.st == pdimf_pkg::PDIMF_ST_OSC),
		.thresh  (r_q.osc_thr),
		.done    (osc_done)
	);

	assign acc_wr   = psel && penable && pwrite;
	assign setup_rd = psel && !penable && !pwrite;

	always_comb
	begin
		logic [11:0] set_mask;
		logic [2:0]  raw_off;
		set_mask = 12'h000;
		raw_off  = 3'h0;
		r_d      = r_q;

		// Read data is captured in the setup phase so the access phase needs no wait.
		if (setup_rd)
		begin
			r_d.prdata = 32'h00000000;
			case (paddr)
				`PDIMF_OFF_PWR_ST:
				begin
					r_d.prdata[`PDIMF_PWR_DOM_LSB +: 4]  = dom_s;
					r_d.prdata[`PDIMF_PWR_CORE_LSB +: 4] = core_s;
				end
				`PDIMF_OFF_IDLE_REQ: r_d.prdata[9:0] = r_q.idle_req;
				`PDIMF_OFF_IDLE_ST:
				begin
					r_d.prdata[`PDIMF_IDLE_ACK_LSB +: 10]  = ack_s;
					r_d.prdata[`PDIMF_IDLE_DONE_LSB +: 10] = done_s;
				end
				`PDIMF_OFF_MODE_CFG: r_d.prdata[`PDIMF_CFG_W-1:0] = r_q.cfg;
				`PDIMF_OFF_FLOW_ST: r_d.prdata[`PDIMF_STEP_LSB +: 12] = r_q.flow_bits;
				`PDIMF_OFF_OSC_THR: r_d.prdata[`PDIMF_OSC_THR_W-1:0] = r_q.osc_thr;
				default: r_d.prdata = 32'h00000000;
			endcase
		end

		if (acc_wr)
		begin
			case (paddr)
				`PDIMF_OFF_IDLE_REQ: r_d.idle_req = pwdata[9:0];
				`PDIMF_OFF_MODE_CFG: r_d.cfg = pwdata[`PDIMF_CFG_W-1:0];
				`PDIMF_OFF_FLOW_ST: r_d.flow_bits = pwdata[`PDIMF_STEP_LSB +: 12];
				`PDIMF_OFF_OSC_THR: r_d.osc_thr = pwdata[`PDIMF_OSC_THR_W-1:0];
				default: r_d.idle_req = r_q.idle_req;
			endcase
		end

		case (r_q.st)
			pdimf_pkg::PDIMF_ST_IDLE:
			begin
				if (r_q.cfg.flow_enable && standby_s)
					r_d.st = pdimf_pkg::PDIMF_ST_SLEEP;
			end
			pdimf_pkg::PDIMF_ST_SLEEP:
			begin
				if (!r_q.cfg.flow_enable)
					r_d.st = pdimf_pkg::PDIMF_ST_IDLE;
				else if (wake_s)
				begin
					r_d.st   = pdimf_pkg::PDIMF_ST_WAKE;
					r_d.step = `PDIMF_STEP_FIRST;
				end
			end
			pdimf_pkg::PDIMF_ST_WAKE:
			begin
				if (!r_q.cfg.flow_enable)
					r_d.st = pdimf_pkg::PDIMF_ST_IDLE;
				else if (step_enabled(r_q.step, r_q.cfg) && r_q.step == `PDIMF_STEP_OSC)
					r_d.st = pdimf_pkg::PDIMF_ST_OSC;
				else
				begin
					if (step_enabled(r_q.step, r_q.cfg))
						set_mask = 12'h001 << r_q.step;
					r_d.step = r_q.step - 4'h1;
					if (r_q.step == 4'h0)
						r_d.st = pdimf_pkg::PDIMF_ST_IDLE;
				end
			end
			pdimf_pkg::PDIMF_ST_OSC:
			begin
				if (!r_q.cfg.flow_enable)
					r_d.st = pdimf_pkg::PDIMF_ST_IDLE;
				else if (osc_done)
				begin
					set_mask = 12'h001 << r_q.step;
					r_d.step = r_q.step - 4'h1;
					r_d.st   = pdimf_pkg::PDIMF_ST_WAKE;
				end
			end
			default: r_d.st = pdimf_pkg::PDIMF_ST_IDLE;
		endcase

		// A step reached in the same cycle as a software write is kept.
		r_d.flow_bits = r_d.flow_bits | set_mask;

		raw_off = {r_q.cfg.whole_chip_off_enable, r_q.cfg.synth_off_enable,
			r_q.cfg.bus_domain_off_enable};
		if (r_q.st != pdimf_pkg::PDIMF_ST_SLEEP)
			r_d.pwroff = 3'h0;
		else if (r_q.cfg.power_off_combine)
			r_d.pwroff = {3{|raw_off}};
		else
			r_d.pwroff = raw_off;

		r_d.pad_release = ~{r_q.cfg.dram1_pad_hold_release_request,
			r_q.cfg.dram0_pad_hold_release_request};
		r_d.core_gate = !r_q.cfg.core_clock_gate_disable &&
			(r_q.st == pdimf_pkg::PDIMF_ST_SLEEP);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_q             <= '0;
			r_q.st          <= pdimf_pkg::PDIMF_ST_IDLE;
			r_q.cfg         <= `PDIMF_CFG_RST;
			r_q.osc_thr     <= `PDIMF_OSC_THR_RST;
			r_q.pad_release <= `PDIMF_PAD_REL_RST;
		end
		else
			r_q <= r_d;
	end

	assign prdata          = r_q.prdata;
	assign pready          = psel && penable;
	assign pslverr         = psel && penable && !addr_mapped(paddr);
	assign idle_req        = r_q.idle_req;
	// Remaining configuration bits steer the clock, DRAM and clamp logic directly.
	assign mode_cfg        = r_q.cfg;
	assign power_off_req   = r_q.pwroff;
	assign pad_release_req = r_q.pad_release;
	assign core_clock_gate = r_q.core_gate;
	assign flow_asleep     = (r_q.st == pdimf_pkg::PDIMF_ST_SLEEP);
	assign flow_steps      = r_q.flow_bits;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_idle_req_write;
		acc_wr && paddr == `PDIMF_OFF_IDLE_REQ |=> idle_req == $past(pwdata[9:0]);
	endproperty
	a_idle_req_write: assert property (p_idle_req_write)
		else $error("idle request did not follow write");

	property p_idle_ack_read;
		setup_rd && paddr == `PDIMF_OFF_IDLE_ST |=>
			prdata[25:16] == $past(ack_s) && prdata[31:26] == 6'h00;
	endproperty
	a_idle_ack_read: assert property (p_idle_ack_read)
		else $error("idle acknowledge field wrong");

	property p_idle_done_read;
		setup_rd && paddr == `PDIMF_OFF_IDLE_ST |=>
			prdata[9:0] == $past(done_s) && prdata[15:10] == 6'h00;
	endproperty
	a_idle_done_read: assert property (p_idle_done_read)
		else $error("idle finished field wrong");

	property p_pwr_st_read;
		setup_rd && paddr == `PDIMF_OFF_PWR_ST |=> prdata[8:5] == $past(dom_s) &&
			prdata[3:0] == $past(core_s) && prdata[4] == 1'b0;
	endproperty
	a_pwr_st_read: assert property (p_pwr_st_read)
		else $error("power status read wrong");

	property p_flow_disabled;
		!mode_cfg.flow_enable |=> r_q.st == pdimf_pkg::PDIMF_ST_IDLE;
	endproperty
	a_flow_disabled: assert property (p_flow_disabled)
		else $error("flow ran while disabled");

	property p_pad_release;
		acc_wr && paddr == `PDIMF_OFF_MODE_CFG |=> ##1
			pad_release_req == ~$past(pwdata[22:21], 2);
	endproperty
	a_pad_release: assert property (p_pad_release)
		else $error("pad release polarity wrong");

	property p_combine;
		flow_asleep && mode_cfg.power_off_combine && mode_cfg.whole_chip_off_enable
			|=> power_off_req == 3'h7;
	endproperty
	a_combine: assert property (p_combine)
		else $error("power-off signals not combined");

	property p_first_step;
		r_q.st == pdimf_pkg::PDIMF_ST_WAKE && r_q.step == `PDIMF_STEP_FIRST &&
			mode_cfg.flow_enable |=> flow_steps[11] && r_q.step == 4'hA;
	endproperty
	a_first_step: assert property (p_first_step)
		else $error("wake-up steps out of order");

	property p_osc_hold;
		r_q.st == pdimf_pkg::PDIMF_ST_OSC && !osc_done && mode_cfg.flow_enable
			|=> r_q.st == pdimf_pkg::PDIMF_ST_OSC && !flow_steps[1];
	endproperty
	a_osc_hold: assert property (p_osc_hold)
		else $error("oscillator wait ended early");

	property p_core_gate;
		mode_cfg.core_clock_gate_disable |=> !core_clock_gate;
	endproperty
	a_core_gate: assert property (p_core_gate)
		else $error("core clock gated while disabled");

	c_sleep: cover property ($rose(flow_asleep));
	c_wake_done: cover property (r_q.st == pdimf_pkg::PDIMF_ST_WAKE && r_q.step == 4'h0);
	c_osc_wait: cover property (r_q.st == pdimf_pkg::PDIMF_ST_OSC && osc_done);
	c_slverr: cover property (pslverr);

endmodule : pdimf_top

// File: test/pdimf_domain_model.sv
module pdimf_domain_model (
	input  wire logic       pclk,       // System clock.
	input  wire logic       presetn,    // Asynchronous reset, active low.
	input  wire logic [9:0] idle_req,   // Flush requests from the block.
	input  wire logic       slow,       // Stretch each flush.
	input  wire logic [7:0] off_set,    // Domain and core off pattern.
	output logic      [9:0] idle_ack,   // Flush acknowledges.
	output logic      [9:0] idle_done,  // Flush finished flags.
	output logic      [3:0] domain_off, // Video, video-out, peri, bus off.
	output logic      [3:0] core_off    // Cores 3..1 and primary off.
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] wait_q [10];

	assign domain_off = off_set[7:4];
	assign core_off   = off_set[3:0];

	// A slow domain needs several cycles to drain before it reports idle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			idle_ack  <= 10'h000;
			idle_done <= 10'h000;
			for (int i = 0; i < 10; i++)
				wait_q[i] <= 3'h0;
		end
		else
		begin
			for (int i = 0; i < 10; i++)
			begin
				if (!idle_req[i])
				begin
					wait_q[i]    <= 3'h0;
					idle_ack[i]  <= 1'b0;
					idle_done[i] <= 1'b0;
				end
				else if (wait_q[i] < (slow ? 3'h6 : 3'h1))
					wait_q[i] <= wait_q[i] + 3'h1;
				else
				begin
					idle_ack[i]  <= 1'b1;
					idle_done[i] <= 1'b1;
				end
			end
		end
	end
endmodule : pdimf_domain_model

// File: test/power_domain_idle_and_mode_flow_test.sv
`include "pdimf_consts.svh"

module power_domain_idle_and_mode_flow_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                       slow, standby, wake, err, gate, asleep;
	logic [7:0]                 paddr, off_set;
	logic [31:0]                pwdata, prdata, rd, e;
	logic [9:0]                 idle_req, ack, done;
	logic [3:0]                 dom_off, core_off;
	logic [2:0]                 pwr_off;
	logic [1:0]                 pad_rel, pe;
	logic [11:0]                steps, nb;
	logic [11:0]                prev_steps = 12'h000;
	pdimf_pkg::pdimf_mode_cfg_t cfg;
	int                         error_cnt = 0;
	int                         checks = 0;
	int                         cyc = 0;
	logic [7:0]                 ra [5] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
	logic [31:0]                rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h05DC0};
	logic [9:0]                 ip [4] = '{10'h001, 10'h200, 10'h2A5, 10'h3FF};
	logic [7:0]                 op [3] = '{8'hFF, 8'hA5, 8'h5A};

	pdimf_top DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .idle_ack_in(ack), .idle_done_in(done),
		.domain_off_in(dom_off), .core_off_in(core_off), .cpu_standby_in(standby),
		.wake_event_in(wake), .idle_req(idle_req), .mode_cfg(cfg),
		.power_off_req(pwr_off), .pad_release_req(pad_rel), .core_clock_gate(gate),
		.flow_asleep(asleep), .flow_steps(steps)
	);

	pdimf_domain_model far_side (
		.pclk(pclk), .presetn(presetn), .idle_req(idle_req), .slow(slow),
		.off_set(off_set), .idle_ack(ack), .idle_done(done),
		.domain_off(dom_off), .core_off(core_off)
	);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic stop_test();
		$display("Mismatches %0d, checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the bench cycle limit ends a stalled access.
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic poll(input logic [7:0] a, input logic [31:0] x);
		int n = 0;
		apb(1'b0, a, 32'h0);
		while (rd !== x && n < 30)
		begin
			apb(1'b0, a, 32'h0);
			n++;
		end
	endtask : poll

	// Sleep, then wake, and compare the steps that the walk leaves behind.
	task automatic run_flow(input logic [31:0] c, input logic [2:0] eo, input logic eg,
		input logic [11:0] es);
		apb(1'b1, `PDIMF_OFF_FLOW_ST, 32'h0);
		apb(1'b1, `PDIMF_OFF_MODE_CFG, c);
		standby <= 1'b1;
		for (int n = 0; n < 50 && asleep !== 1'b1; n++)
			@(posedge pclk);
		// Power-off and gate outputs settle one cycle after the sleep state.
		@(posedge pclk);
		chk(asleep, 1'b1);
		chk(pwr_off, eo);
		chk(gate, eg);
		standby <= 1'b0;
		@(posedge pclk);
		wake <= 1'b1;
		for (int n = 0; n < 200 && steps !== es; n++)
			@(posedge pclk);
		wake <= 1'b0;
		chk(steps, es);
		// Let the walk run past every remaining step before reading it back.
		repeat (16) @(posedge pclk);
		apb(1'b0, `PDIMF_OFF_FLOW_ST, 32'h0);
		chk(rd, {1'b0, es, 19'h0});
		chk(asleep, 1'b0);
		chk(gate, 1'b0);
		chk(pwr_off, 3'h0);
		apb(1'b1, `PDIMF_OFF_MODE_CFG, 32'h0);
	endtask : run_flow

	// Newly reached steps must all lie below every step already reached.
	always @(posedge pclk)
	begin
		nb = steps & ~prev_steps;
		if (nb != 12'h0 && prev_steps != 12'h0)
			chk(32'(nb < (prev_steps & -prev_steps)), 32'h1);
		prev_steps = steps;
	end

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slow = 1'b0;
		standby = 1'b0;
		wake = 1'b0;
		off_set = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pad_rel, 2'h3);
		chk(idle_req, 10'h0);
		for (int i = 0; i < 5; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		for (int i = 0; i < 4; i++)
		begin
			slow <= i[0];
			apb(1'b1, `PDIMF_OFF_IDLE_REQ, {22'h3FFFFF, ip[i]});
			chk(idle_req, ip[i]);
			apb(1'b0, `PDIMF_OFF_IDLE_REQ, 32'h0);
			chk(rd, ip[i]);
			poll(`PDIMF_OFF_IDLE_ST, {6'h0, ip[i], 6'h0, ip[i]});
			chk(rd, {6'h0, ip[i], 6'h0, ip[i]});
			apb(1'b1, `PDIMF_OFF_IDLE_ST, 32'hFFFFFFFF);
			apb(1'b0, `PDIMF_OFF_IDLE_ST, 32'h0);
			chk(rd, {6'h0, ip[i], 6'h0, ip[i]});
			apb(1'b1, `PDIMF_OFF_IDLE_REQ, 32'h0);
			poll(`PDIMF_OFF_IDLE_ST, 32'h0);
			chk(rd, 32'h0);
		end
		for (int i = 0; i < 3; i++)
		begin
			off_set <= op[i];
			poll(`PDIMF_OFF_PWR_ST, {23'h0, op[i][7:4], 1'b0, op[i][3:0]});
			chk(rd, {23'h0, op[i][7:4], 1'b0, op[i][3:0]});
		end
		off_set <= 8'h00;
		for (int i = 0; i < 23; i++)
		begin
			e = 32'h1 << i;
			pe = ~e[22:21];
			apb(1'b1, `PDIMF_OFF_MODE_CFG, e | 32'hFF800000);
			repeat (2) @(posedge pclk);
			chk(cfg, e);
			chk(pad_rel, pe);
			apb(1'b0, `PDIMF_OFF_MODE_CFG, 32'h0);
			chk(rd, e);
		end
		apb(1'b1, `PDIMF_OFF_MODE_CFG, 32'h0);
		apb(1'b1, `PDIMF_OFF_FLOW_ST, 32'hFFFFFFFF);
		apb(1'b0, `PDIMF_OFF_FLOW_ST, 32'h0);
		chk(rd, 32'h7FF80000);
		apb(1'b1, `PDIMF_OFF_OSC_THR, 32'h3);
		apb(1'b0, `PDIMF_OFF_OSC_THR, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b0, 8'h11, 32'h0);
		chk(err, 1'b1);
		run_flow(32'h301, 3'h7, 1'b1, 12'hC00);
		run_flow(32'h7FFD7F, 3'h5, 1'b0, 12'hFEF);
		// A flow that is switched off must neither sleep nor stay asleep.
		apb(1'b1, `PDIMF_OFF_MODE_CFG, 32'h300);
		standby <= 1'b1;
		repeat (20) @(posedge pclk);
		chk(asleep, 1'b0);
		apb(1'b1, `PDIMF_OFF_MODE_CFG, 32'h1);
		for (int n = 0; n < 50 && asleep !== 1'b1; n++)
			@(posedge pclk);
		chk(asleep, 1'b1);
		standby <= 1'b0;
		apb(1'b1, `PDIMF_OFF_MODE_CFG, 32'h0);
		@(posedge pclk);
		chk(asleep, 1'b0);
		stop_test();
	end
endmodule : power_domain_idle_and_mode_flow_test
